// File: link_event_pkg.sv
// Shared constants for the link-layer event monitor: event codes, unit-mask
// field positions, message class codes and the power-state type.
// Assumes one link-layer clock; all users import this package whole.
package link_event_pkg;

  localparam int NUM_COUNTERS       = 4;
  localparam int NUM_SLOTS          = 3;
  localparam int LANES_DEFAULT      = 20;
  localparam int DISABLED_LANE_PCT  = 60;
  localparam int OCC_WIDTH_DEFAULT  = 5;
  localparam int EXT_WIDTH          = 24;

  // Event codes carried in the counter control register.
  localparam logic [7:0] EV_TX_FLITS     = 8'h02;
  localparam logic [7:0] EV_HDR_MATCH    = 8'h04;
  localparam logic [7:0] EV_FULL_POWER   = 8'h26;
  localparam logic [7:0] EV_PARTIAL      = 8'h27;
  localparam logic [7:0] EV_RX_ALLOC     = 8'h30;
  localparam logic [7:0] EV_RX_FILL      = 8'h32;
  localparam logic [7:0] EV_TX_SKIP      = 8'h41;

  // Unit-mask field positions.
  localparam int UMASK_SLOT_LSB  = 0;
  localparam int UMASK_TYPE_LSB  = 3;
  localparam int UMASK_CLASS_LSB = 0;
  localparam int UMASK_OPC_LSB   = 4;
  // Bit 32 of the control register is bit 0 of the extension field.
  localparam int EXT_OPC_EN_BIT  = 0;

  // Slot header type bits, in the order of unit-mask bits 7:3.
  localparam int TYPE_DATA    = 0;
  localparam int TYPE_LLCRD   = 1;
  localparam int TYPE_NULL    = 2;
  localparam int TYPE_LLCTRL  = 3;
  localparam int TYPE_PROTHDR = 4;
  localparam int TYPE_WIDTH   = 5;

  // Message class codes in the low unit-mask nibble.
  localparam logic [3:0] CLASS_REQUEST       = 4'h8;
  localparam logic [3:0] CLASS_PROBE         = 4'h9;
  localparam logic [3:0] CLASS_REPLY_NO_DATA = 4'ha;
  localparam logic [3:0] CLASS_REPLY_DATA    = 4'hc;
  localparam logic [3:0] CLASS_WRITE_BACK    = 4'hd;
  localparam logic [3:0] CLASS_NC_BYPASS     = 4'he;
  localparam logic [3:0] CLASS_NC_STANDARD   = 4'hf;

  typedef enum logic [1:0] {
    PWR_TRAINING,
    PWR_FULL,
    PWR_PARTIAL
  } power_state_type;

endpackage : link_event_pkg

// File: link_power_tracker.sv
// Power-state tracker for one direction of the link.
// Assumes training and partial-width requests come from same-clock logic.
`timescale 1ns/1ps
module link_power_tracker
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic training_in,
  input  wire logic partial_width_req_in,
  output logic      full_power_out,
  output logic      partial_width_out,
  output logic      partial_entry_out
);
  import link_event_pkg::*;

  power_state_type state_r;
  power_state_type state_nxt;
  logic            full_r;
  logic            full_nxt;
  logic            partial_r;
  logic            partial_nxt;
  logic            entry_r;
  logic            entry_nxt;

  // Training outranks everything; partial width is a sub-mode of full power.
  always_comb
  begin
    if (training_in)
      state_nxt = PWR_TRAINING;
    else if (partial_width_req_in)
      state_nxt = PWR_PARTIAL;
    else
      state_nxt = PWR_FULL;
    full_nxt    = (state_nxt != PWR_TRAINING);
    partial_nxt = (state_nxt == PWR_PARTIAL);
    entry_nxt   = (state_nxt == PWR_PARTIAL) && (state_r != PWR_PARTIAL);
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_r   <= PWR_TRAINING;
      full_r    <= 1'b0;
      partial_r <= 1'b0;
      entry_r   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      full_r    <= full_nxt;
      partial_r <= partial_nxt;
      entry_r   <= entry_nxt;
    end
  end

  assign full_power_out    = full_r;
  assign partial_width_out = partial_r;
  assign partial_entry_out = entry_r;

  property p_entry_once;
    @(posedge clock_in) disable iff (rst_in)
    partial_entry_out |=> !partial_entry_out;
  endproperty
  a_entry_once: assert property (p_entry_once)
    else $error("partial-width entry pulse lasted more than one cycle");

endmodule : link_power_tracker

// File: link_layer_event_monitor.sv
// Event selection for four link-layer performance counters, with the
// receive steering, transmit queue choice and lane control they observe.
// Assumes all inputs come from logic on the same link-layer clock and
// that an external counter core adds count_inc_out each cycle.
// Operation
// - Code 0x30 counts receive buffer allocations per unit-mask slot.
// - Code 0x32 adds receive queue fill every cycle per slot.
// - Received flits bypass the queue unless the ring is stalled.
// - Every event is available on counters 0 through 3.
// - Code 0x27 counts cycles with transmit in partial width.
// - Partial width disables 60% of the transmit lanes.
// - Rising-transition option makes code 0x27 count state entries.
// - Entry counting is unreliable while deep-sleep count is nonzero.
// - Power state is tracked separately for transmit and receive.
// - Code 0x26 counts full-power cycles including partial width.
// - Training cycles are not counted as full power.
// - Code 0x04 counts transmit headers matching extension filters.
// - Filters are ANDed within a slot, slot results ORed.
// - Low nibble picks class; bit 32 adds opcode match on 7:4.
// - Code 0x41 counts flits bypassing the transmit buffer.
// - Transmit queue is used in partial width or during retry.
// - Code 0x02 counts valid transmitted flits only.
// - Mask bits 0..2 pick slots; upper bits pick header types.
// - Type bits are ORed per chosen slot, results summed.
`timescale 1ns/1ps
module link_layer_event_monitor
#(
  parameter int LANES     = link_event_pkg::LANES_DEFAULT,
  parameter int OCC_WIDTH = link_event_pkg::OCC_WIDTH_DEFAULT
)
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic [link_event_pkg::NUM_COUNTERS-1:0] counter_enable_in,
  input  wire logic [link_event_pkg::NUM_COUNTERS-1:0][7:0] event_code_in,
  input  wire logic [link_event_pkg::NUM_COUNTERS-1:0][7:0] unit_mask_in,
  input  wire logic [link_event_pkg::NUM_COUNTERS-1:0]
                    [link_event_pkg::EXT_WIDTH-1:0] unit_mask_ext_in,
  input  wire logic [link_event_pkg::NUM_COUNTERS-1:0] rising_edge_in,
  input  wire logic deep_sleep_count_nonzero_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0] rx_slot_valid_in,
  input  wire logic ring_stall_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0][OCC_WIDTH-1:0]
                    rx_queue_fill_in,
  input  wire logic tx_training_in,
  input  wire logic tx_partial_width_req_in,
  input  wire logic rx_training_in,
  input  wire logic rx_partial_width_req_in,
  input  wire logic tx_send_in,
  input  wire logic tx_retry_in,
  input  wire logic tx_flit_valid_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0]
                    [link_event_pkg::TYPE_WIDTH-1:0] tx_slot_type_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0] tx_hdr_valid_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0][3:0] tx_hdr_class_in,
  input  wire logic [link_event_pkg::NUM_SLOTS-1:0][3:0] tx_hdr_opcode_in,
  output logic      [link_event_pkg::NUM_COUNTERS-1:0][OCC_WIDTH+1:0]
                    count_inc_out,
  output logic      [link_event_pkg::NUM_COUNTERS-1:0] edge_unreliable_out,
  output logic      [link_event_pkg::NUM_SLOTS-1:0] rx_to_queue_out,
  output logic      tx_use_queue_out,
  output logic      [LANES-1:0] tx_lane_enable_out,
  output logic      tx_full_power_out,
  output logic      tx_partial_width_out,
  output logic      rx_full_power_out,
  output logic      rx_partial_width_out
);
  import link_event_pkg::*;

  localparam int INC_W          = OCC_WIDTH + 2;
  localparam int DISABLED_LANES = (LANES * DISABLED_LANE_PCT) / 100;
  localparam int ACTIVE_LANES   = LANES - DISABLED_LANES;

  // Lane split must come out whole, and fill sums must fit the increment.
  if ((LANES * DISABLED_LANE_PCT) % 100 != 0 || LANES < 5)
    $error("LANES must allow an exact 60 percent lane split");
  if (OCC_WIDTH < 1 || OCC_WIDTH > 16)
    $error("OCC_WIDTH out of supported range");

  function automatic logic [1:0] slot_sum
  (
    input logic [NUM_SLOTS-1:0] hits
  );
    slot_sum = {1'b0, hits[0]} + {1'b0, hits[1]} + {1'b0, hits[2]};
  endfunction : slot_sum

  function automatic logic legal_class
  (
    input logic [3:0] code
  );
    legal_class = (code == CLASS_REQUEST) || (code == CLASS_PROBE) ||
                  (code == CLASS_REPLY_NO_DATA) ||
                  (code == CLASS_REPLY_DATA) ||
                  (code == CLASS_WRITE_BACK) ||
                  (code == CLASS_NC_BYPASS) ||
                  (code == CLASS_NC_STANDARD);
  endfunction : legal_class

  // Per-direction power state.
  logic tx_full;
  logic tx_partial;
  logic tx_entry;

  link_power_tracker u_tx_power
  (
    .clock_in             (clock_in),
    .rst_in               (rst_in),
    .training_in          (tx_training_in),
    .partial_width_req_in (tx_partial_width_req_in),
    .full_power_out       (tx_full),
    .partial_width_out    (tx_partial),
    .partial_entry_out    (tx_entry)
  );

  link_power_tracker u_rx_power
  (
    .clock_in             (clock_in),
    .rst_in               (rst_in),
    .training_in          (rx_training_in),
    .partial_width_req_in (rx_partial_width_req_in),
    .full_power_out       (rx_full_power_out),
    .partial_width_out    (rx_partial_width_out),
    .partial_entry_out    ()
  );

  assign tx_full_power_out    = tx_full;
  assign tx_partial_width_out = tx_partial;

  // Path steering and lane control.
  logic [NUM_SLOTS-1:0] rx_alloc;
  logic                 tx_queue_sel;
  logic                 tx_skip;
  logic [NUM_SLOTS-1:0] rx_queue_r;
  logic [NUM_SLOTS-1:0] rx_queue_nxt;
  logic                 use_queue_r;
  logic                 use_queue_nxt;
  logic [LANES-1:0]     lanes_r;
  logic [LANES-1:0]     lanes_nxt;
  logic [LANES-1:0]     partial_mask;

  // Upper lanes are the ones shut down in partial width.
  assign partial_mask = {{DISABLED_LANES{1'b0}}, {ACTIVE_LANES{1'b1}}};

  always_comb
  begin
    rx_alloc      = rx_slot_valid_in & {NUM_SLOTS{ring_stall_in}};
    tx_queue_sel  = tx_partial | tx_retry_in;
    tx_skip       = tx_send_in & ~tx_queue_sel;
    rx_queue_nxt  = rx_alloc;
    use_queue_nxt = tx_queue_sel;
    lanes_nxt     = tx_partial ? partial_mask : {LANES{1'b1}};
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rx_queue_r  <= '0;
      use_queue_r <= 1'b0;
      lanes_r     <= '0;
    end
    else
    begin
      rx_queue_r  <= rx_queue_nxt;
      use_queue_r <= use_queue_nxt;
      lanes_r     <= lanes_nxt;
    end
  end

  assign rx_to_queue_out    = rx_queue_r;
  assign tx_use_queue_out   = use_queue_r;
  assign tx_lane_enable_out = lanes_r;

  // Event selection, one copy per counter.
  for (genvar c = 0; c < NUM_COUNTERS; c++)
  begin : g_counter
    logic [INC_W-1:0]     inc_r;
    logic [INC_W-1:0]     inc_nxt;
    logic                 unrel_r;
    logic                 unrel_nxt;
    logic [NUM_SLOTS-1:0] slot_sel;
    logic [NUM_SLOTS-1:0] hdr_hit;
    logic [NUM_SLOTS-1:0] flit_hit;
    logic [TYPE_WIDTH-1:0] type_sel;
    logic [3:0]           cls_sel;
    logic [3:0]           opc_sel;
    logic                 opc_en;

    always_comb
    begin
      slot_sel = unit_mask_in[c][UMASK_SLOT_LSB +: NUM_SLOTS];
      type_sel = unit_mask_in[c][UMASK_TYPE_LSB +: TYPE_WIDTH];
      cls_sel  = unit_mask_in[c][UMASK_CLASS_LSB +: 4];
      opc_sel  = unit_mask_in[c][UMASK_OPC_LSB +: 4];
      opc_en   = unit_mask_ext_in[c][EXT_OPC_EN_BIT];
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
        hdr_hit[s]  = tx_hdr_valid_in[s] && legal_class(cls_sel) &&
                      (tx_hdr_class_in[s] == cls_sel) &&
                      (!opc_en || tx_hdr_opcode_in[s] == opc_sel);
        flit_hit[s] = tx_flit_valid_in && slot_sel[s] &&
                      |(type_sel & tx_slot_type_in[s]);
      end
      inc_nxt   = '0;
      unrel_nxt = counter_enable_in[c] && rising_edge_in[c] &&
                  (event_code_in[c] == EV_PARTIAL) &&
                  deep_sleep_count_nonzero_in;
      if (counter_enable_in[c])
      begin
        unique case (event_code_in[c])
          EV_RX_ALLOC:
            inc_nxt = INC_W'(slot_sum(slot_sel & rx_alloc));
          EV_RX_FILL:
            inc_nxt = (slot_sel[0] ? INC_W'(rx_queue_fill_in[0]) : '0) +
                      (slot_sel[1] ? INC_W'(rx_queue_fill_in[1]) : '0) +
                      (slot_sel[2] ? INC_W'(rx_queue_fill_in[2]) : '0);
          EV_PARTIAL:
            inc_nxt = INC_W'(rising_edge_in[c] ? tx_entry
                                               : tx_partial);
          EV_FULL_POWER:
            inc_nxt = INC_W'(tx_full);
          EV_HDR_MATCH:
            inc_nxt = INC_W'(|hdr_hit);
          EV_TX_SKIP:
            inc_nxt = INC_W'(tx_skip);
          EV_TX_FLITS:
            inc_nxt = INC_W'(slot_sum(flit_hit));
          default:
            inc_nxt = '0;
        endcase
      end
    end

    always_ff @(posedge clock_in)
    begin
      if (rst_in)
      begin
        inc_r   <= '0;
        unrel_r <= 1'b0;
      end
      else
      begin
        inc_r   <= inc_nxt;
        unrel_r <= unrel_nxt;
      end
    end

    assign count_inc_out[c]       = inc_r;
    assign edge_unreliable_out[c] = unrel_r;
  end

  // Each check watches at most one counter, plus the shared steering outputs.
  property p_rx_alloc;
    @(posedge clock_in) disable iff (rst_in)
    (counter_enable_in[0] && event_code_in[0] == EV_RX_ALLOC &&
     unit_mask_in[0] == 8'h07 && rx_slot_valid_in == 3'h7 && ring_stall_in)
    |=> count_inc_out[0] == INC_W'(3);
  endproperty
  a_rx_alloc: assert property (p_rx_alloc)
    else $error("allocation count wrong for three stalled slots");

  property p_rx_fill;
    @(posedge clock_in) disable iff (rst_in)
    (counter_enable_in[0] && event_code_in[0] == EV_RX_FILL &&
     unit_mask_in[0][2:0] == 3'h5)
    |=> count_inc_out[0] == INC_W'($past(rx_queue_fill_in[0])) +
                            INC_W'($past(rx_queue_fill_in[2]));
  endproperty
  a_rx_fill: assert property (p_rx_fill)
    else $error("fill increment does not match selected slots");

  property p_rx_bypass;
    @(posedge clock_in) disable iff (rst_in)
    !ring_stall_in |=> rx_to_queue_out == 3'h0;
  endproperty
  a_rx_bypass: assert property (p_rx_bypass)
    else $error("flit queued while ring not stalled");

  property p_partial_cycles;
    @(posedge clock_in) disable iff (rst_in)
    (counter_enable_in[1] && event_code_in[1] == EV_PARTIAL &&
     !rising_edge_in[1] && tx_partial_width_out)
    |=> count_inc_out[1] == INC_W'(1);
  endproperty
  a_partial_cycles: assert property (p_partial_cycles)
    else $error("partial-width cycle not counted");

  property p_lanes;
    @(posedge clock_in) disable iff (rst_in)
    tx_partial_width_out |=> tx_lane_enable_out == partial_mask;
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("lane enables wrong in partial width");

  property p_edge_count;
    @(posedge clock_in) disable iff (rst_in)
    (counter_enable_in[2] && event_code_in[2] == EV_PARTIAL &&
     rising_edge_in[2] && tx_partial_width_out && $past(tx_partial_width_out))
    |=> count_inc_out[2] == '0;
  endproperty
  a_edge_count: assert property (p_edge_count)
    else $error("entry count advanced while staying in partial width");

  property p_training;
    @(posedge clock_in) disable iff (rst_in)
    (tx_training_in && counter_enable_in[0] &&
     event_code_in[0] == EV_FULL_POWER) ##1
    (counter_enable_in[0] && event_code_in[0] == EV_FULL_POWER)
    |=> count_inc_out[0] == '0;
  endproperty
  a_training: assert property (p_training)
    else $error("training cycle counted as full power");

  property p_retry_queue;
    @(posedge clock_in) disable iff (rst_in)
    (tx_retry_in && tx_send_in && counter_enable_in[3] &&
     event_code_in[3] == EV_TX_SKIP)
    |=> tx_use_queue_out && count_inc_out[3] == '0;
  endproperty
  a_retry_queue: assert property (p_retry_queue)
    else $error("retry did not force the transmit queue");

  property p_no_slot;
    @(posedge clock_in) disable iff (rst_in)
    (event_code_in[2] == EV_TX_FLITS && unit_mask_in[2][2:0] == 3'h0)
    |=> count_inc_out[2] == '0;
  endproperty
  a_no_slot: assert property (p_no_slot)
    else $error("flits counted with no slot selected");

  property p_disabled;
    @(posedge clock_in) disable iff (rst_in)
    !counter_enable_in[1] |=> count_inc_out[1] == '0;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled counter received an increment");

endmodule : link_layer_event_monitor

// File: link_port_model.sv
// Far-side link port model that presents transmit headers per slot.
// Assumes the bench calls send_header from its own procedures.
`timescale 1ns/1ps
module link_port_model
(
  input  wire logic                                    clock_in,
  output logic [link_event_pkg::NUM_SLOTS-1:0]         hdr_valid_out,
  output logic [link_event_pkg::NUM_SLOTS-1:0][3:0]    hdr_class_out,
  output logic [link_event_pkg::NUM_SLOTS-1:0][3:0]    hdr_opcode_out
);
  import link_event_pkg::*;

  initial
  begin
    hdr_valid_out  = '0;
    hdr_class_out  = '0;
    hdr_opcode_out = '0;
  end

  // A header stands one cycle. Afterwards the fields are inverted, which
  // leaves no legal class, so stale fields match no class filter even if valid is ignored.
  task automatic send_header(input logic [NUM_SLOTS-1:0] slots,
                             input logic [NUM_SLOTS-1:0][3:0] cls,
                             input logic [NUM_SLOTS-1:0][3:0] opc);
    @(negedge clock_in);
    hdr_valid_out  = slots;
    hdr_class_out  = cls;
    hdr_opcode_out = opc;
    @(negedge clock_in);
    hdr_valid_out  = '0;
    hdr_class_out  = ~cls;
    hdr_opcode_out = ~opc;
  endtask : send_header
endmodule : link_port_model

// File: tb.sv
// Self-checking bench for the link-layer event monitor.
// Assumes the default lane count of 20 and a fill width of 5 bits.
`timescale 1ns/1ps
module tb;
  import link_event_pkg::*;

  logic                                  clock_in = 1'b0;
  logic                                  rst_in;
  logic [NUM_COUNTERS-1:0]               en;
  logic [NUM_COUNTERS-1:0]               edg;
  logic [NUM_COUNTERS-1:0][7:0]          code;
  logic [NUM_COUNTERS-1:0][7:0]          umask;
  logic [NUM_COUNTERS-1:0][EXT_WIDTH-1:0] ext;
  logic                                  sleep_nz;
  logic                                  stall;
  logic                                  tx_train;
  logic                                  tx_preq;
  logic                                  rx_train;
  logic                                  rx_preq;
  logic                                  send;
  logic                                  retry;
  logic                                  fvalid;
  logic [NUM_SLOTS-1:0]                  rx_valid;
  logic [NUM_SLOTS-1:0]                  hvalid;
  logic [NUM_SLOTS-1:0][4:0]             fill;
  logic [NUM_SLOTS-1:0][TYPE_WIDTH-1:0]  stype;
  logic [NUM_SLOTS-1:0][3:0]             hclass;
  logic [NUM_SLOTS-1:0][3:0]             hopc;
  logic [NUM_COUNTERS-1:0][6:0]          inc;
  logic [NUM_COUNTERS-1:0]               unrel;
  logic [NUM_SLOTS-1:0]                  to_q;
  logic                                  use_q;
  logic                                  tx_full;
  logic                                  tx_part;
  logic                                  rx_full;
  logic                                  rx_part;
  logic [19:0]                           lanes;
  int                                    fails;
  int                                    n_tests;
  int                                    cycles;
  logic [3:0]                            cls [7];

  link_layer_event_monitor #(.LANES(20), .OCC_WIDTH(5)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .counter_enable_in(en),
    .event_code_in(code), .unit_mask_in(umask), .unit_mask_ext_in(ext),
    .rising_edge_in(edg), .deep_sleep_count_nonzero_in(sleep_nz),
    .rx_slot_valid_in(rx_valid), .ring_stall_in(stall),
    .rx_queue_fill_in(fill), .tx_training_in(tx_train),
    .tx_partial_width_req_in(tx_preq), .rx_training_in(rx_train),
    .rx_partial_width_req_in(rx_preq), .tx_send_in(send),
    .tx_retry_in(retry), .tx_flit_valid_in(fvalid),
    .tx_slot_type_in(stype), .tx_hdr_valid_in(hvalid),
    .tx_hdr_class_in(hclass), .tx_hdr_opcode_in(hopc),
    .count_inc_out(inc), .edge_unreliable_out(unrel),
    .rx_to_queue_out(to_q), .tx_use_queue_out(use_q),
    .tx_lane_enable_out(lanes), .tx_full_power_out(tx_full),
    .tx_partial_width_out(tx_part), .rx_full_power_out(rx_full),
    .rx_partial_width_out(rx_part));

  link_port_model peer (
    .clock_in(clock_in), .hdr_valid_out(hvalid),
    .hdr_class_out(hclass), .hdr_opcode_out(hopc));

  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk_count(input int i, input logic [6:0] exp);
    n_tests++;
    if (inc[i] !== exp)
    begin
      fails++;
      $display("MISMATCH count_inc[%0d] expected %0h seen %0h", i, exp,
               inc[i]);
    end
  endtask : chk_count

  task automatic chk_sig(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_sig

  // Moves to the next falling edge, where last cycle's results are settled.
  task automatic step;
    @(negedge clock_in);
  endtask : step

  task automatic rx_alloc_test;
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      en = 4'h1 << i;
      code[i] = EV_RX_ALLOC;
      umask[i] = 8'h07;
      rx_valid = 3'h7;
      stall = 1'b1;
      step();
      chk_count(i, 7'h03);
      chk_sig("rx_to_queue", 20'h0_0007, 20'(to_q));
    end
    umask[3] = 8'h05;
    rx_valid = 3'h7;
    step();
    chk_count(3, 7'h02);
    stall = 1'b0;
    step();
    chk_count(3, 7'h00);
    chk_sig("rx_to_queue", 20'h0_0000, 20'(to_q));
    rx_valid = '0;
  endtask : rx_alloc_test

  task automatic rx_fill_test;
    en = 4'h1;
    code[0] = EV_RX_FILL;
    umask[0] = 8'h07;
    fill = {5'h1f, 5'h1f, 5'h1f};
    step();
    chk_count(0, 7'h5d);
    umask[0] = 8'h05;
    fill = {5'h09, 5'h07, 5'h03};
    step();
    chk_count(0, 7'h0c);
  endtask : rx_fill_test

  task automatic power_test;
    en = 4'hf;
    code = {EV_TX_SKIP, EV_PARTIAL, EV_PARTIAL, EV_FULL_POWER};
    edg = 4'h4;
    send = 1'b1;
    step();
    chk_count(0, 7'h01);
    chk_count(1, 7'h00);
    chk_count(3, 7'h01);
    chk_sig("lanes", 20'hf_ffff, lanes);
    tx_preq = 1'b1;
    step();
    step();
    chk_count(1, 7'h01);
    chk_count(2, 7'h01);
    chk_count(0, 7'h01);
    chk_count(3, 7'h00);
    chk_sig("lanes", 20'h0_00ff, lanes);
    chk_sig("use_queue", 20'h0_0001, 20'(use_q));
    chk_sig("rx_state", 20'h0_0001, {18'h0, rx_part, rx_full});
    sleep_nz = 1'b1;
    step();
    chk_count(2, 7'h00);
    chk_count(1, 7'h01);
    chk_sig("unreliable", 20'h0_0004, 20'(unrel));
    tx_train = 1'b1;
    rx_preq = 1'b1;
    step();
    step();
    chk_count(0, 7'h00);
    chk_count(1, 7'h00);
    chk_sig("rx_state", 20'h0_0003, {18'h0, rx_part, rx_full});
    tx_train = 1'b0;
    tx_preq = 1'b0;
    sleep_nz = 1'b0;
    rx_preq = 1'b0;
    rx_train = 1'b1;
    step();
    step();
    chk_sig("rx_state", 20'h0_0000, {18'h0, rx_part, rx_full});
    chk_sig("tx_state", 20'h0_0002, {18'h0, tx_full, tx_part});
    rx_train = 1'b0;
  endtask : power_test

  task automatic retry_test;
    en = 4'h8;
    retry = 1'b1;
    step();
    chk_count(3, 7'h00);
    retry = 1'b0;
    step();
    chk_count(3, 7'h01);
    send = 1'b0;
    step();
    chk_count(3, 7'h00);
  endtask : retry_test

  task automatic hdr_test;
    en = 4'h1;
    code[0] = EV_HDR_MATCH;
    ext[0] = 24'h00_0000;
    for (int k = 0; k < 7; k++)
    begin
      umask[0] = {4'h0, cls[k]};
      peer.send_header(3'h2, {3{cls[k]}}, '0);
      chk_count(0, 7'h01);
      peer.send_header(3'h2, {3{cls[(k + 1) % 7]}}, '0);
      chk_count(0, 7'h00);
    end
    ext[0] = 24'h00_0001;
    umask[0] = {4'h5, CLASS_PROBE};
    peer.send_header(3'h1, {3{CLASS_PROBE}}, {3{4'h5}});
    chk_count(0, 7'h01);
    peer.send_header(3'h1, {3{CLASS_PROBE}}, {3{4'h6}});
    chk_count(0, 7'h00);
    peer.send_header(3'h3, {CLASS_PROBE, CLASS_REQUEST, CLASS_PROBE},
                     {4'h5, 4'h5, 4'h6});
    chk_count(0, 7'h00);
    peer.send_header(3'h5, {3{CLASS_PROBE}}, {3{4'h5}});
    chk_count(0, 7'h01);
  endtask : hdr_test

  task automatic flit_test;
    en = 4'h4;
    code[2] = EV_TX_FLITS;
    umask[2] = 8'h0d;
    stype = {5'h01, 5'h01, 5'h01};
    fvalid = 1'b1;
    step();
    chk_count(2, 7'h02);
    fvalid = 1'b0;
    step();
    chk_count(2, 7'h00);
    fvalid = 1'b1;
    stype = {5'h04, 5'h10, 5'h10};
    umask[2] = 8'h87;
    step();
    chk_count(2, 7'h02);
    umask[2] = 8'ha7;
    step();
    chk_count(2, 7'h03);
    umask[2] = 8'hf8;
    step();
    chk_count(2, 7'h00);
    code[2] = 8'h03;
    step();
    chk_count(2, 7'h00);
    code[2] = EV_TX_FLITS;
    en = 4'h0;
    step();
    chk_count(2, 7'h00);
  endtask : flit_test

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    cls = '{CLASS_REQUEST, CLASS_PROBE, CLASS_REPLY_NO_DATA, CLASS_REPLY_DATA,
            CLASS_WRITE_BACK, CLASS_NC_BYPASS, CLASS_NC_STANDARD};
    fails = 0;
    n_tests = 0;
    cycles = 0;
    rst_in = 1'b1;
    {en, edg, code, umask, ext} = '0;
    {sleep_nz, stall, tx_train, tx_preq, send, retry, fvalid} = '0;
    {rx_train, rx_preq} = '0;
    rx_valid = '0;
    fill = '0;
    stype = '0;
    step();
    step();
    chk_sig("reset_lanes", 20'h0_0000, lanes);
    chk_sig("reset_state", 20'h0_0000, {18'h0, tx_full, tx_part});
    rst_in = 1'b0;
    step();
    step();
    rx_alloc_test();
    rx_fill_test();
    power_test();
    retry_test();
    hdr_test();
    flit_test();
    give_verdict();
  end
endmodule : tb
